//--- inc/flash_access_pkg.sv
// Purpose: constants shared by the flash access control block
// Assumes: 100 MHz pclk, APB register access, 16-bit core addresses
// Notes: register word index times four gives the APB byte address
// Operation
// - one-shot enable set lets a timer switch sense amps off after reads
// - read-always set forces a flash read every clock; clear reads on demand
// - reserved flash control bits read zero; software writes zeros there
// - user write/erase enable must be set before any flash write or erase acts
// - program store control upper five bits read zero, writes ignored
// - scratchpad select steers user flash accesses to the 128-byte sector
// - erase and write enables together make a write erase the whole page
// - the data byte of an erasing write is ignored
// - program write enable steers writes to flash, else to external RAM
// - the sector holding the lock bytes cannot be erased, only written
package flash_access_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned ONESHOT_NS = 40;
	localparam int unsigned ONESHOT_CYCLES_RAW =
		(ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ONESHOT_CYCLES =
		(ONESHOT_CYCLES_RAW < 1) ? 1 : ONESHOT_CYCLES_RAW;
	localparam int unsigned APB_AW = 12;
	localparam logic [11:0] PSC_INDEX = 12'h08f;
	localparam logic [11:0] FMC_INDEX = 12'h0b7;
	localparam logic [11:0] PSC_ADDR = PSC_INDEX << 2;
	localparam logic [11:0] FMC_ADDR = FMC_INDEX << 2;
	localparam logic [7:0] FMC_RESET = 8'h80;
	localparam logic [7:0] PSC_RESET = 8'h00;
	localparam logic [7:0] FMC_WMASK = 8'hc1;
	localparam logic [7:0] PSC_WMASK = 8'h07;
	localparam int unsigned FMC_ONESHOT_BIT = 7;
	localparam int unsigned FMC_RDALWAYS_BIT = 6;
	localparam int unsigned FMC_USERWE_BIT = 0;
	localparam int unsigned PSC_SCRATCH_BIT = 2;
	localparam int unsigned PSC_ERASE_BIT = 1;
	localparam int unsigned PSC_PROGWE_BIT = 0;
	localparam logic [15:0] LOCK_SECTOR_BASE = 16'hfc00;
	localparam int unsigned SECTOR_SHIFT = 9;
	localparam logic [15:0] SCRATCH_MASK = 16'h007f;
	localparam logic [7:0] ERASE_DATA = 8'h00;

	function automatic logic same_sector(input logic [15:0] a,
		input logic [15:0] b);
		return a[15:SECTOR_SHIFT] == b[15:SECTOR_SHIFT];
	endfunction

	function automatic logic [31:0] reg_word(input logic [7:0] v);
		return {24'h000000, v};
	endfunction
endpackage

//--- inc/flash_cmd_if.sv
`timescale 1ns/1ps
// Purpose: carries one external-move request and its steering decision
// Assumes: single pclk domain, decision is combinational
// Notes: src side is the top level, dst side is the router
interface flash_cmd_if;
	logic req;
	logic wr;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic scratch;
	logic erase_en;
	logic prog_we;
	logic user_we;
	logic flash_wr;
	logic flash_er;
	logic xram_wr;
	logic refused;
	logic [15:0] addr_out;
	logic [7:0] data_out;
	modport src (output req, wr, addr, wdata, scratch, erase_en, prog_we,
		user_we, input flash_wr, flash_er, xram_wr, refused, addr_out,
		data_out);
	modport dst (input req, wr, addr, wdata, scratch, erase_en, prog_we,
		user_we, output flash_wr, flash_er, xram_wr, refused, addr_out,
		data_out);
endinterface // flash_cmd_if

//--- verilog/flash_write_router.sv
`timescale 1ns/1ps
// Purpose: decide where an external-move write goes
// Assumes: inputs are stable within the cycle of the request
// Notes: purely combinational; the top level registers the result
module flash_write_router #(
	parameter logic [15:0] LOCK_BASE = flash_access_pkg::LOCK_SECTOR_BASE
) (
	flash_cmd_if.dst cmd
);
	logic is_wr;
	logic to_flash;
	logic lock_hit;

	always_comb
	begin
		is_wr = cmd.req && cmd.wr;
		to_flash = cmd.prog_we;
		lock_hit = !cmd.scratch &&
			flash_access_pkg::same_sector(cmd.addr, LOCK_BASE);
		cmd.flash_wr = 1'b0;
		cmd.flash_er = 1'b0;
		cmd.xram_wr = 1'b0;
		cmd.refused = 1'b0;
		cmd.addr_out = cmd.scratch ?
			(cmd.addr & flash_access_pkg::SCRATCH_MASK) : cmd.addr;
		cmd.data_out = cmd.wdata;
		if (is_wr && !to_flash)
		begin
			cmd.xram_wr = 1'b1;
		end
		else if (is_wr && !cmd.user_we)
		begin
			cmd.refused = 1'b1;
		end
		else if (is_wr && cmd.erase_en)
		begin
			cmd.data_out = flash_access_pkg::ERASE_DATA;
			cmd.flash_er = !lock_hit;
			cmd.refused = lock_hit;
		end
		else if (is_wr)
		begin
			cmd.flash_wr = 1'b1;
		end
	end
endmodule // flash_write_router

//--- verilog/sense_amp_timer.sv
`timescale 1ns/1ps
// Purpose: hold the flash sense amplifiers on around reads
// Assumes: read_pulse comes from logic on pclk
// Notes: with the timer off the amplifiers simply stay powered
module sense_amp_timer #(
	parameter int unsigned HOLD_CYCLES = flash_access_pkg::ONESHOT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic oneshot_en,
	input wire logic read_pulse,
	output logic amp_on
);
	localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYCLES);
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;

	// timer shuts amps after a read
	always_comb
	begin
		count_next = count_reg;
		if (read_pulse)
			count_next = HOLD_LOAD;
		else if (count_reg != '0)
			count_next = count_reg - 1'b1;
		amp_on = !oneshot_en || read_pulse || (count_reg != '0);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end
endmodule // sense_amp_timer

//--- verilog/flash_access_ctrl.sv
`timescale 1ns/1ps
// Purpose: program flash access control with two APB registers
// Assumes: core request ports run on pclk; zero-wait APB slave
// Notes: all outputs are registered, so results follow one cycle late
module flash_access_ctrl #(
	parameter logic [15:0] LOCK_BASE = flash_access_pkg::LOCK_SECTOR_BASE,
	parameter int unsigned HOLD_CYCLES = flash_access_pkg::ONESHOT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic xmove_valid,
	input wire logic xmove_write,
	input wire logic [15:0] xmove_addr,
	input wire logic [7:0] xmove_wdata,
	input wire logic core_read_req,
	output logic flash_write_stb,
	output logic flash_erase_stb,
	output logic [15:0] flash_addr,
	output logic [7:0] flash_data,
	output logic flash_scratch_sel,
	output logic xram_write_stb,
	output logic [15:0] xram_addr,
	output logic [7:0] xram_data,
	output logic flash_read_stb,
	output logic sense_amp_on,
	output logic write_refused
);
	logic [7:0] fmc_reg;
	logic [7:0] fmc_next;
	logic [7:0] psc_reg;
	logic [7:0] psc_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic setup;
	logic wr_take;
	logic hit_fmc;
	logic hit_psc;
	logic read_pulse;
	logic amp_on;
	logic fwr_reg;
	logic fer_reg;
	logic xwr_reg;
	logic ref_reg;
	logic rd_reg;
	logic amp_reg;
	logic scr_reg;
	logic [15:0] faddr_reg;
	logic [7:0] fdata_reg;
	logic [15:0] xaddr_reg;
	logic [7:0] xdata_reg;
	logic [15:0] faddr_next;
	logic [7:0] fdata_next;
	logic [15:0] xaddr_next;
	logic [7:0] xdata_next;
	logic scr_next;

	flash_cmd_if cmd ();

	assign cmd.req = xmove_valid;
	assign cmd.wr = xmove_write;
	assign cmd.addr = xmove_addr;
	assign cmd.wdata = xmove_wdata;
	assign cmd.scratch = psc_reg[flash_access_pkg::PSC_SCRATCH_BIT];
	assign cmd.erase_en = psc_reg[flash_access_pkg::PSC_ERASE_BIT];
	assign cmd.prog_we = psc_reg[flash_access_pkg::PSC_PROGWE_BIT];
	assign cmd.user_we = fmc_reg[flash_access_pkg::FMC_USERWE_BIT];

	flash_write_router #(
		.LOCK_BASE(LOCK_BASE)
	) u_router (
		.cmd(cmd)
	);

	assign read_pulse = fmc_reg[flash_access_pkg::FMC_RDALWAYS_BIT] ||
		core_read_req;

	sense_amp_timer #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_amp (
		.pclk(pclk),
		.presetn(presetn),
		.oneshot_en(fmc_reg[flash_access_pkg::FMC_ONESHOT_BIT]),
		.read_pulse(read_pulse),
		.amp_on(amp_on)
	);

	// answer prepared in setup so the access phase is zero-wait
	always_comb
	begin
		setup = psel && !penable;
		wr_take = psel && penable && pready_reg && pwrite;
		hit_fmc = paddr == flash_access_pkg::FMC_ADDR;
		hit_psc = paddr == flash_access_pkg::PSC_ADDR;
		pready_next = setup;
		pslverr_next = setup && !hit_fmc && !hit_psc;
		prdata_next = '0;
		if (setup && !pwrite && hit_fmc)
			prdata_next = flash_access_pkg::reg_word(fmc_reg);
		else if (setup && !pwrite && hit_psc)
			prdata_next = flash_access_pkg::reg_word(psc_reg);
		fmc_next = fmc_reg;
		psc_next = psc_reg;
		if (wr_take && hit_fmc)
			fmc_next = pwdata[7:0] & flash_access_pkg::FMC_WMASK;
		if (wr_take && hit_psc)
			psc_next = pwdata[7:0] & flash_access_pkg::PSC_WMASK;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fmc_reg <= flash_access_pkg::FMC_RESET;
			psc_reg <= flash_access_pkg::PSC_RESET;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			fmc_reg <= fmc_next;
			psc_reg <= psc_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// addresses and data only move with their strobe
	always_comb
	begin
		faddr_next = faddr_reg;
		fdata_next = fdata_reg;
		scr_next = scr_reg;
		xaddr_next = xaddr_reg;
		xdata_next = xdata_reg;
		if (cmd.flash_wr || cmd.flash_er)
		begin
			faddr_next = cmd.addr_out;
			fdata_next = cmd.data_out;
			scr_next = cmd.scratch;
		end
		if (cmd.xram_wr)
		begin
			xaddr_next = xmove_addr;
			xdata_next = xmove_wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fwr_reg <= 1'b0;
			fer_reg <= 1'b0;
			xwr_reg <= 1'b0;
			ref_reg <= 1'b0;
			rd_reg <= 1'b0;
			amp_reg <= 1'b0;
			scr_reg <= 1'b0;
			faddr_reg <= '0;
			fdata_reg <= '0;
			xaddr_reg <= '0;
			xdata_reg <= '0;
		end
		else
		begin
			fwr_reg <= cmd.flash_wr;
			fer_reg <= cmd.flash_er;
			xwr_reg <= cmd.xram_wr;
			ref_reg <= cmd.refused;
			rd_reg <= read_pulse;
			amp_reg <= amp_on;
			scr_reg <= scr_next;
			faddr_reg <= faddr_next;
			fdata_reg <= fdata_next;
			xaddr_reg <= xaddr_next;
			xdata_reg <= xdata_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign flash_write_stb = fwr_reg;
	assign flash_erase_stb = fer_reg;
	assign flash_addr = faddr_reg;
	assign flash_data = fdata_reg;
	assign flash_scratch_sel = scr_reg;
	assign xram_write_stb = xwr_reg;
	assign xram_addr = xaddr_reg;
	assign xram_data = xdata_reg;
	assign flash_read_stb = rd_reg;
	assign sense_amp_on = amp_reg;
	assign write_refused = ref_reg;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic first_reg;
	logic [7:0] idle_cnt_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_reg <= 1'b1;
			idle_cnt_reg <= '0;
		end
		else
		begin
			first_reg <= 1'b0;
			if (read_pulse)
				idle_cnt_reg <= '0;
			else if (idle_cnt_reg != 8'hff)
				idle_cnt_reg <= idle_cnt_reg + 8'h01;
		end
	end

	logic wr_now;
	assign wr_now = xmove_valid && xmove_write;

	// a freshly set enable may still see amps held from free running
	chk_oneshot_off: assert property (
		fmc_reg[7] && $past(fmc_reg[7]) &&
		idle_cnt_reg > 8'(HOLD_CYCLES + 1) |-> !sense_amp_on)
		else $error("sense amps still on after one-shot expiry");
	chk_amp_on_read: assert property (
		read_pulse |=> sense_amp_on)
		else $error("sense amps off in the cycle after a read");
	chk_amp_free_run: assert property (
		!fmc_reg[7] ##1 !fmc_reg[7] |-> sense_amp_on)
		else $error("sense amps off with one-shot timer disabled");
	chk_read_always: assert property (
		fmc_reg[6] |=> flash_read_stb)
		else $error("no flash read while read-always set");
	chk_read_demand: assert property (
		!fmc_reg[6] && !core_read_req |=> !flash_read_stb)
		else $error("flash read with no demand and read-always clear");
	chk_reserved_zero: assert property (
		pready && !pslverr && psel && !pwrite &&
		paddr == flash_access_pkg::FMC_ADDR |-> prdata[5:1] == 5'h00)
		else $error("reserved flash control bits read nonzero");
	chk_reserved_store: assert property (
		fmc_reg[5:1] == 5'h00)
		else $error("reserved flash control bits stored");
	chk_reset_value: assert property (
		first_reg |-> fmc_reg == flash_access_pkg::FMC_RESET &&
		psc_reg == flash_access_pkg::PSC_RESET)
		else $error("control registers wrong after reset");
	chk_unused_ignored: assert property (
		psel && penable && pwrite &&
		paddr == flash_access_pkg::PSC_ADDR
		|=> psc_reg[7:3] == 5'h00 && psc_reg[2:0] == $past(pwdata[2:0]))
		else $error("program store control write misbehaved");
	chk_user_gate: assert property (
		wr_now && !fmc_reg[0] |=> !flash_write_stb && !flash_erase_stb)
		else $error("flash changed with user enable clear");
	chk_discard_write: assert property (
		wr_now && !fmc_reg[0] && psc_reg[0] |=> write_refused && !xram_write_stb)
		else $error("disabled flash write not discarded");
	chk_scratch_steer: assert property (
		wr_now && fmc_reg[0] && psc_reg[0] && psc_reg[2]
		|=> flash_scratch_sel && flash_addr[15:7] == 9'h000)
		else $error("scratchpad write not steered");
	chk_page_erase: assert property (
		wr_now && fmc_reg[0] && psc_reg[1:0] == 2'b11 && psc_reg[2]
		|=> flash_erase_stb && !flash_write_stb)
		else $error("erase-enabled write did not erase");
	chk_erase_data: assert property (
		flash_erase_stb |-> flash_data == 8'h00)
		else $error("erase carried a data byte");
	chk_xram_steer: assert property (
		wr_now && !psc_reg[0] |=> xram_write_stb && !flash_write_stb
		&& xram_data == $past(xmove_wdata))
		else $error("write with program enable clear not sent to RAM");
	chk_lock_erase: assert property (
		wr_now && fmc_reg[0] && psc_reg == 8'h03 && xmove_addr[15:9] == 7'h7e
		|=> !flash_erase_stb && write_refused)
		else $error("lock sector erased");

	cov_page_erase: cover property (flash_erase_stb);
	cov_scratch_write: cover property (flash_write_stb && flash_scratch_sel);
	cov_refused: cover property (write_refused);
	cov_oneshot_off: cover property (fmc_reg[7] && !sense_amp_on);
	cov_scratch_erase: cover property (flash_erase_stb && flash_scratch_sel);
endmodule // flash_access_ctrl

//--- tb/testbench.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the flash access control block
// Assumes: zero-wait APB slave, one-shot hold shortened to 2 cycles
// Notes: strobes are looked at 1 ns after the edge that launches them
module testbench;
	localparam int unsigned HOLD = 2;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic xmove_valid;
	logic xmove_write;
	logic [15:0] xmove_addr;
	logic [7:0] xmove_wdata;
	logic core_read_req;
	logic flash_write_stb;
	logic flash_erase_stb;
	logic [15:0] flash_addr;
	logic [7:0] flash_data;
	logic flash_scratch_sel;
	logic xram_write_stb;
	logic [15:0] xram_addr;
	logic [7:0] xram_data;
	logic flash_read_stb;
	logic sense_amp_on;
	logic write_refused;
	logic [31:0] rd;
	logic err;
	int fails;
	int total_checks;

	flash_access_ctrl #(.HOLD_CYCLES(HOLD)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .xmove_valid(xmove_valid),
		.xmove_write(xmove_write), .xmove_addr(xmove_addr),
		.xmove_wdata(xmove_wdata), .core_read_req(core_read_req),
		.flash_write_stb(flash_write_stb), .flash_erase_stb(flash_erase_stb),
		.flash_addr(flash_addr), .flash_data(flash_data),
		.flash_scratch_sel(flash_scratch_sel),
		.xram_write_stb(xram_write_stb), .xram_addr(xram_addr),
		.xram_data(xram_data), .flash_read_stb(flash_read_stb),
		.sense_amp_on(sense_amp_on), .write_refused(write_refused));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic cmp(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// request held until pready is sampled high, then released
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends a wait for the slave
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h00000000);
		cmp("prdata", {24'h000000, exp}, rd);
		cmp("pslverr", 32'h00000000, {31'h00000000, err});
	endtask

	task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
		apb(1'b1, a, {24'h000000, v});
	endtask

	// exp_s bits: flash write, flash erase, xram write, refused
	task automatic xw(input logic [15:0] a, input logic [7:0] d,
		input logic [3:0] exp_s, input logic [15:0] ea, input logic [7:0] ed);
		@(posedge pclk);
		xmove_valid <= 1'b1;
		xmove_write <= 1'b1;
		xmove_addr <= a;
		xmove_wdata <= d;
		@(posedge pclk);
		xmove_valid <= 1'b0;
		#1;
		cmp("strobes", {28'h0000000, exp_s}, {28'h0000000, flash_write_stb,
			flash_erase_stb, xram_write_stb, write_refused});
		if (exp_s[3] || exp_s[2])
		begin
			cmp("flash_addr", {16'h0000, ea}, {16'h0000, flash_addr});
			cmp("flash_data", {24'h000000, ed}, {24'h000000, flash_data});
		end
		if (exp_s[1])
		begin
			cmp("xram_addr", {16'h0000, ea}, {16'h0000, xram_addr});
			cmp("xram_data", {24'h000000, ed}, {24'h000000, xram_data});
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	initial
	begin
		#20000;
		fails++;
		summarize();
	end

	initial
	begin
		fails = 0;
		total_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		xmove_valid = 1'b0;
		xmove_write = 1'b0;
		xmove_addr = 16'h0000;
		xmove_wdata = 8'h00;
		core_read_req = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(flash_access_pkg::FMC_ADDR, 8'h80);
		rd_chk(flash_access_pkg::PSC_ADDR, 8'h00);
		wr_reg(flash_access_pkg::FMC_ADDR, 8'hff);
		rd_chk(flash_access_pkg::FMC_ADDR, 8'hc1);
		wr_reg(flash_access_pkg::PSC_ADDR, 8'hf8);
		rd_chk(flash_access_pkg::PSC_ADDR, 8'h00);
		apb(1'b0, 12'h100, 32'h00000000);
		cmp("unmapped pslverr", 32'h00000001, {31'h00000000, err});
		// user write enable off: writes land in external RAM, or are refused once program write enable is set
		wr_reg(flash_access_pkg::FMC_ADDR, 8'h80);
		xw(16'h1234, 8'h5a, 4'h2, 16'h1234, 8'h5a);
		wr_reg(flash_access_pkg::PSC_ADDR, 8'h01);
		xw(16'h2000, 8'ha5, 4'h1, 16'h0000, 8'h00);
		wr_reg(flash_access_pkg::PSC_ADDR, 8'h03);
		xw(16'h2200, 8'h33, 4'h1, 16'h0000, 8'h00);
		wr_reg(flash_access_pkg::FMC_ADDR, 8'h81);
		// the page is erased before any byte is stored into it
		wr_reg(flash_access_pkg::PSC_ADDR, 8'h03);
		xw(16'h3400, 8'hee, 4'h4, 16'h3400, 8'h00);
		wr_reg(flash_access_pkg::PSC_ADDR, 8'h01);
		xw(16'h3456, 8'hc3, 4'h8, 16'h3456, 8'hc3);
		xw(16'hfdfe, 8'h7e, 4'h8, 16'hfdfe, 8'h7e);
		cmp("scratch sel", 32'h00000000, {31'h0, flash_scratch_sel});
		wr_reg(flash_access_pkg::PSC_ADDR, 8'h05);
		xw(16'h0073, 8'h11, 4'h8, 16'h0073, 8'h11);
		cmp("scratch sel", 32'h00000001, {31'h0, flash_scratch_sel});
		wr_reg(flash_access_pkg::PSC_ADDR, 8'h03);
		xw(16'h4321, 8'h99, 4'h4, 16'h4321, 8'h00);
		xw(16'hfc10, 8'h99, 4'h1, 16'h0000, 8'h00);
		xw(16'hfbff, 8'h42, 4'h4, 16'hfbff, 8'h00);
		wr_reg(flash_access_pkg::PSC_ADDR, 8'h07);
		xw(16'h0040, 8'h55, 4'h4, 16'h0040, 8'h00);
		cmp("scratch erase sel", 32'h1, {31'h0, flash_scratch_sel});
		wr_reg(flash_access_pkg::PSC_ADDR, 8'h00);
		// reads on demand, then the one-shot switching the amps off
		cyc(HOLD + 4);
		cmp("read stb idle", 32'h0, {31'h0, flash_read_stb});
		cmp("amps off", 32'h0, {31'h0, sense_amp_on});
		@(posedge pclk);
		core_read_req <= 1'b1;
		@(posedge pclk);
		core_read_req <= 1'b0;
		#1;
		cmp("read stb", 32'h1, {31'h0, flash_read_stb});
		cmp("amps on", 32'h1, {31'h0, sense_amp_on});
		cyc(1);
		cmp("read stb once", 32'h0, {31'h0, flash_read_stb});
		cyc(HOLD + 2);
		cmp("amps timed off", 32'h0, {31'h0, sense_amp_on});
		wr_reg(flash_access_pkg::FMC_ADDR, 8'hc0);
		cyc(2);
		cmp("read always", 32'h1, {31'h0, flash_read_stb});
		cyc(1);
		cmp("read always", 32'h1, {31'h0, flash_read_stb});
		// one-shot off: amps stay powered after the last read
		wr_reg(flash_access_pkg::FMC_ADDR, 8'h00);
		cyc(HOLD + 6);
		cmp("read stb off", 32'h0, {31'h0, flash_read_stb});
		cmp("amps held", 32'h1, {31'h0, sense_amp_on});
		// second reset in mid-run must restore both registers
		wr_reg(flash_access_pkg::PSC_ADDR, 8'h07);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(flash_access_pkg::FMC_ADDR, 8'h80);
		rd_chk(flash_access_pkg::PSC_ADDR, 8'h00);
		cyc(1);
		cmp("amps after reset", 32'h0, {31'h0, sense_amp_on});
		summarize();
	end
endmodule // testbench
